// File: rtl/hbpc_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// - Reset loads input register with top three bits high, rest low.
// - Undervoltage lasting past the delay sets supply fail and disables outputs.
// - Outputs return at once when the load supply is normal again.
// - Supply fail stays set until host writes status clear high.
// - Open-load detect low enables pull currents on high and low switches.
// - Open-load results of all six switches appear in status bits 1 to 6.
// - A switch turned on drops open-load detection for that output only.
// - Thermal warning sets above set threshold, clears below reset threshold.
// - Thermal warning is visible early; an aborted read changes only the read data.
// - Thermal shutdown disables that output, forces status low, sets overload.
// - Thermal shutdown output returns only when cool and status clear written.
// - Overcurrent with shutdown enabled switches off after delay, sets overload.
// - Overcurrent shutdown disabled means no overcurrent switch-off or overload.
// - Status clear write clears overload and re-enables protected outputs.
// - Soft run low holds outputs off; register port keeps working.
// - PWM pin gates outputs whose PWM select and switch-on bits are set.
// - Input register holds clear, switches, PWM selects, detect, shutdown, run.
// - Status word holds warning, switch states, overload, standby, supply fail.
// - Standby flag reads as the inverse of the soft-run bit.
module hbpc_ctrl
  import hbpc_pkg::*;
#(
  parameter int UV_DELAY = UV_DELAY_CYC,
  parameter int OC_DELAY = OC_DELAY_CYC
) (
  // Clock and reset.
  input  wire logic              CORE_CLK,
  input  wire logic              RESET_N,
  // Register port.
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WR_DATA,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  output logic      [DATA_W-1:0] RD_DATA,
  // Comparator levels and the PWM pin.
  input  wire hbpc_sense_t       SENSE,
  // Output stage controls.
  output logic      [NSW-1:0]    DRIVE_ON,
  output logic      [NSW-1:0]    OL_PULL_EN,
  // Early thermal warning line.
  output logic                   THERM_WARN
);

  // Registered state and its next value.
  hbpc_state_t s_q;
  hbpc_state_t s_d;

  // Filtered copy of the outside levels.
  hbpc_sense_t sn;

  // Decoded controls and helper terms.
  logic           wr_input;
  logic           clr_wr;
  logic           rd_input;
  logic           rd_status;
  logic [NSW-1:0] sw_on;
  logic [NSW-1:0] pwm_sel;
  logic           detect_on;
  logic           oc_en;
  logic           soft_run;
  logic [NSW-1:0] th_event;
  logic [NSW-1:0] oc_event;
  logic [NSW-1:0] sw_stat;
  logic [15:0]    status_word;

  // Every comparator and the PWM pin are asynchronous to the core clock.
  hbpc_sync #(
    .WIDTH ($bits(hbpc_sense_t))
  ) u_sync (
    .CORE_CLK (CORE_CLK),
    .RESET_N  (RESET_N),
    .ASYNC_IN (SENSE),
    .SYNC_OUT (sn)
  );

  // Field decode of the stored input register.
  always_comb begin
    sw_on     = s_q.in_reg[IN_SWITCH_LSB +: NSW];
    pwm_sel   = s_q.in_reg[IN_PWM_LSB +: NSW];
    detect_on = ~s_q.in_reg[IN_OPENLOAD_N];
    oc_en     = s_q.in_reg[IN_OC_EN];
    soft_run  = s_q.in_reg[IN_SOFT_RUN];
  end

  // Port decode; a status-clear write is recognised in the cycle of the write.
  always_comb begin
    wr_input  = WR_EN && (ADDR == ADDR_INPUT);
    clr_wr    = wr_input && WR_DATA[IN_STATUS_CLEAR];
    rd_input  = RD_EN && (ADDR == ADDR_INPUT);
    rd_status = RD_EN && (ADDR == ADDR_STATUS);
  end

  // Per-switch status bit. While detection covers an idle switch the bit
  // shows the open-load comparator; otherwise it shows whether the stage
  // conducts. A protected switch always reads low so software can find it.
  always_comb begin
    for (int i = 0; i < NSW; i++) begin
      if (s_q.th_off[i] || s_q.oc_off[i]) begin
        sw_stat[i] = 1'b0;
      end else if (detect_on && !sw_on[i]) begin
        sw_stat[i] = sn.ol[i];
      end else begin
        sw_stat[i] = s_q.drive[i];
      end
    end
  end

  // Assemble the status word; unused bits read as zero.
  always_comb begin
    status_word                            = 16'h0000;
    status_word[ST_THERM_WARN]             = s_q.tw;
    status_word[ST_SWITCH_LSB +: NSW]      = sw_stat;
    status_word[ST_OVERLOAD]               = s_q.overload_flag;
    status_word[ST_STANDBY]                = ~soft_run;
    status_word[ST_SUPPLY_FAIL]            = s_q.sfail;
  end

  // Protection events of this cycle.
  always_comb begin
    for (int i = 0; i < NSW; i++) begin
      // A hot stage is caught once; the latch holds it afterwards.
      th_event[i] = sn.sd[i] && !s_q.th_off[i];
      // The overcurrent timer only runs while shutdown is enabled.
      oc_event[i] = oc_en && sn.oc[i] && s_q.drive[i] && !s_q.oc_off[i]
                    && (s_q.oc_cnt[i] == CNT_W'(OC_DELAY - 1));
    end
  end

  // Next-state logic for the whole controller.
  always_comb begin
    s_d = s_q;

    // Software writes replace the whole input register. Reads only load
    // the read data register, so a transfer that is abandoned early is harmless.
    if (wr_input) begin
      s_d.in_reg = WR_DATA;
    end

    // Undervoltage filter: count while low, trip once the delay has passed,
    // and drop the trip the moment the supply is back in range.
    if (sn.uv) begin
      if (s_q.uv_cnt == CNT_W'(UV_DELAY)) begin
        s_d.uv_act = 1'b1;
      end else begin
        s_d.uv_cnt = s_q.uv_cnt + CNT_W'(1);
      end
    end else begin
      s_d.uv_cnt = '0;
      s_d.uv_act = 1'b0;
    end

    // Supply fail is sticky; a trip in the clearing cycle wins.
    if (s_d.uv_act) begin
      s_d.sfail = 1'b1;
    end else if (clr_wr) begin
      s_d.sfail = 1'b0;
    end

    // Per-switch thermal and overcurrent latches.
    for (int i = 0; i < NSW; i++) begin
      // Thermal latch: set while hot; released by a clear only once cool.
      if (sn.sd[i]) begin
        s_d.th_off[i] = 1'b1;
      end else if (clr_wr) begin
        s_d.th_off[i] = 1'b0;
      end

      // Overcurrent delay counter runs only on a conducting, enabled stage.
      if (oc_en && sn.oc[i] && s_q.drive[i] && !s_q.oc_off[i]) begin
        if (!oc_event[i]) begin
          s_d.oc_cnt[i] = s_q.oc_cnt[i] + CNT_W'(1);
        end else begin
          s_d.oc_cnt[i] = '0;
        end
      end else begin
        s_d.oc_cnt[i] = '0;
      end

      // Overcurrent latch; an event in the clearing cycle wins.
      if (oc_event[i]) begin
        s_d.oc_off[i] = 1'b1;
      end else if (clr_wr) begin
        s_d.oc_off[i] = 1'b0;
      end
    end

    // Overload flag: set by any thermal or overcurrent shutdown, cleared by a status-clear write.
    if (|th_event || |oc_event) begin
      s_d.overload_flag = 1'b1;
    end else if (clr_wr) begin
      s_d.overload_flag = 1'b0;
    end

    // Thermal warning with hysteresis: any stage above set threshold sets
    // it, and it only clears once every stage is below the reset threshold.
    if (|sn.warn_set) begin
      s_d.tw = 1'b1;
    end else if (&sn.warn_clr) begin
      s_d.tw = 1'b0;
    end

    // Output stage gating. The new latch values are used so that a stage
    // is switched off in the same edge that the protection trips.
    for (int i = 0; i < NSW; i++) begin
      s_d.drive[i] = sw_on[i]
                     && !s_d.th_off[i] && !s_d.oc_off[i]
                     && !s_d.uv_act
                     && soft_run
                     && (!pwm_sel[i] || sn.pwm);
      // Pull currents only on idle switches while detection is selected.
      s_d.ol_pull[i] = detect_on && !sw_on[i];
    end

    // Read data stands only in the cycle after the read strobe.
    if (rd_input) begin
      s_d.rdata = s_q.in_reg;
    end else if (rd_status) begin
      s_d.rdata = status_word;
    end else begin
      s_d.rdata = 16'h0000;
    end
  end

  // State register; reset loads the input register defaults.
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      s_q        <= '0;
      s_q.in_reg <= INPUT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign RD_DATA    = s_q.rdata;
  assign DRIVE_ON   = s_q.drive;
  assign OL_PULL_EN = s_q.ol_pull;
  assign THERM_WARN = s_q.tw;

endmodule

// File: inc/hbpc_pkg.sv
// Shared constants and carriers for the half-bridge protection controller.
package hbpc_pkg;

  // Number of output switches: low and high side of three legs.
  localparam int NSW = 6;

  // Core clock period in nanoseconds (100 MHz).
  localparam int CLK_PERIOD_NS = 10;

  // Least undervoltage persistence before the supply is judged failed.
  localparam int T_DUV_NS     = 10000;
  localparam int UV_DELAY_CYC = (T_DUV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Overcurrent shutdown delay, a plain default to be matched to the analog filter.
  localparam int T_DSD_NS     = 5000;
  localparam int OC_DELAY_CYC = (T_DSD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the delay counters.
  localparam int CNT_W = 16;

  // Register port geometry and word offsets.
  localparam int         ADDR_W      = 4;
  localparam int         DATA_W      = 16;
  localparam logic [3:0] ADDR_INPUT  = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // Input register field positions.
  localparam int IN_STATUS_CLEAR = 0;
  localparam int IN_SWITCH_LSB   = 1;
  localparam int IN_PWM_LSB      = 7;
  localparam int IN_OPENLOAD_N   = 13;
  localparam int IN_OC_EN        = 14;
  localparam int IN_SOFT_RUN     = 15;

  // Status word field positions.
  localparam int ST_THERM_WARN  = 0;
  localparam int ST_SWITCH_LSB  = 1;
  localparam int ST_OVERLOAD    = 13;
  localparam int ST_STANDBY     = 14;
  localparam int ST_SUPPLY_FAIL = 15;

  // Input register value after reset.
  localparam logic [15:0] INPUT_RESET = 16'hE000;

  // Analog comparator and pin levels, all from outside the clock domain.
  typedef struct packed {
    logic           pwm;
    logic           uv;
    logic [NSW-1:0] ol;
    logic [NSW-1:0] oc;
    logic [NSW-1:0] warn_set;
    logic [NSW-1:0] warn_clr;
    logic [NSW-1:0] sd;
  } hbpc_sense_t;

  // Whole state of the controller.
  typedef struct packed {
    logic [15:0]                in_reg;
    logic [NSW-1:0]             th_off;
    logic [NSW-1:0]             oc_off;
    logic [NSW-1:0][CNT_W-1:0]  oc_cnt;
    logic [CNT_W-1:0]           uv_cnt;
    logic                       uv_act;
    logic                       sfail;
    logic                       overload_flag;
    logic                       tw;
    logic [NSW-1:0]             drive;
    logic [NSW-1:0]             ol_pull;
    logic [15:0]                rdata;
  } hbpc_state_t;

endpackage

// File: rtl/hbpc_sync.sv
`timescale 1ns/1ns
// Three-stage synchroniser with a two-sample agreement filter per bit.
module hbpc_sync #(
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input  wire logic             CORE_CLK,
  input  wire logic             RESET_N,
  // Asynchronous levels in, filtered levels out.
  input  wire logic [WIDTH-1:0] ASYNC_IN,
  output logic      [WIDTH-1:0] SYNC_OUT
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } hbpc_sync_st_t;

  hbpc_sync_st_t st_q;
  hbpc_sync_st_t st_d;

  // The first stage feeds only the second; the filter looks at stages two and three.
  always_comb begin
    st_d    = st_q;
    st_d.s1 = ASYNC_IN;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.filt[i] = st_q.s3[i];
      end
    end
  end

  // Synchronous reset clears every stage to a constant.
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign SYNC_OUT = st_q.filt;

endmodule

// File: test/hbpc_monitor.sv
`timescale 1ns/1ns
// Port-level checker; it shadows the input register from the write strobes.
module hbpc_monitor
  import hbpc_pkg::*;
#(
  parameter int UV_DELAY = UV_DELAY_CYC,
  parameter int OC_DELAY = OC_DELAY_CYC
) (
  // Clock and reset.
  input wire logic              CORE_CLK,
  input wire logic              RESET_N,
  // Register port.
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WR_DATA,
  input wire logic              WR_EN,
  input wire logic              RD_EN,
  input wire logic [DATA_W-1:0] RD_DATA,
  // Sense levels and stage controls.
  input wire hbpc_sense_t       SENSE,
  input wire logic [NSW-1:0]    DRIVE_ON,
  input wire logic [NSW-1:0]    OL_PULL_EN,
  input wire logic              THERM_WARN
);
  logic [15:0] shadow_q;
  logic [15:0] uv_run_q;
  wire         rd_st = RD_EN && ADDR == ADDR_STATUS;
  wire         rd_in = RD_EN && ADDR == ADDR_INPUT;

  // Shadow register and a saturating count of undervoltage cycles.
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      shadow_q <= INPUT_RESET;
      uv_run_q <= 16'h0000;
    end else begin
      if (WR_EN && ADDR == ADDR_INPUT) begin
        shadow_q <= WR_DATA;
      end
      uv_run_q <= !SENSE.uv ? 16'h0000 : uv_run_q + {15'h0000, uv_run_q != 16'hFFFF};
    end
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  chk_rd_zero: assert property (!RD_EN |=> RD_DATA == 16'h0000)
    else $error("read data not zero outside a read");
  chk_input_readback: assert property (rd_in |=> RD_DATA == $past(shadow_q))
    else $error("input register read back wrong");
  chk_standby_bit: assert property (rd_st |=> RD_DATA[ST_STANDBY] == !$past(shadow_q[15]))
    else $error("standby flag not inverse of soft run");
  chk_unused_bits: assert property (rd_st |=> RD_DATA[12:7] == 6'h00)
    else $error("unused status bits set");
  chk_status_drive: assert property (rd_st && shadow_q[13] ##1 $stable(DRIVE_ON)
    |-> RD_DATA[6:1] == DRIVE_ON)
    else $error("switch status differs from drive");
  chk_soft_off: assert property (!shadow_q[IN_SOFT_RUN] |=> DRIVE_ON == 6'h00)
    else $error("stage driven in standby");
  chk_drive_cause: assert property ((DRIVE_ON & ~$past(shadow_q[6:1])) == 6'h00)
    else $error("stage driven without its switch-on bit");
  // The margin of ten covers the synchroniser and the output register.
  chk_uv_off: assert property (uv_run_q > UV_DELAY + 10 |-> DRIVE_ON == 6'h00)
    else $error("stage driven during lasting undervoltage");
  chk_pull_drive: assert property ((OL_PULL_EN & DRIVE_ON) == 6'h00)
    else $error("pull current on a driven stage");
  chk_pull_detect: assert property (shadow_q[13] |=> OL_PULL_EN == 6'h00)
    else $error("pull current with detection off");
  chk_warn_clear: assert property ((&SENSE.warn_clr && SENSE.warn_set == 6'h00) [*8]
    |-> !THERM_WARN)
    else $error("thermal warning stuck after cooling");

  cover property (rd_st ##1 RD_DATA[ST_OVERLOAD]);
  cover property (rd_st ##1 RD_DATA[ST_SUPPLY_FAIL]);
  cover property ($fell(THERM_WARN));
endmodule

bind hbpc_ctrl hbpc_monitor #(.UV_DELAY(UV_DELAY), .OC_DELAY(OC_DELAY)) u_hbpc_monitor (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
  .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .SENSE(SENSE),
  .DRIVE_ON(DRIVE_ON), .OL_PULL_EN(OL_PULL_EN), .THERM_WARN(THERM_WARN));

// File: test/hbpc_plant.sv
`timescale 1ns/1ns
// Loads and comparators beyond the output stages.
module hbpc_plant
  import hbpc_pkg::*;
(
  // Levels chosen by the bench.
  input  wire logic           pwm,
  input  wire logic           uv,
  input  wire logic [NSW-1:0] open_load,
  input  wire logic [NSW-1:0] oc,
  input  wire logic [NSW-1:0] warn_set,
  input  wire logic [NSW-1:0] warn_clr,
  input  wire logic [NSW-1:0] sd,
  // Pull currents and conducting stages from the controller.
  input  wire logic [NSW-1:0] pull_en,
  input  wire logic [NSW-1:0] drive,
  // Motor wired between legs one and two.
  input  wire logic           motor,
  // Levels seen by the controller.
  output hbpc_sense_t         sense
);
  logic [NSW-1:0] bridge;

  // With the motor in place, a conducting stage of leg one drags the matching idle
  // stage of leg two past its threshold; a broken motor leaves that stage unseen.
  assign bridge = {2'b00, drive[1:0], 2'b00} & {NSW{motor}} & pull_en;
  // A connected load sinks the pull current, so apart from the motor bridge only an open output trips its comparator.
  assign sense = '{pwm, uv, (pull_en & open_load) | bridge, oc, warn_set, warn_clr, sd};
endmodule

// File: test/tb.sv
`timescale 1ns/1ns
// Register-level bench for the half-bridge protection controller.
module tb;
  import hbpc_pkg::*;
  logic              core_clk = 1'b0;
  logic              reset_n  = 1'b0;
  logic [ADDR_W-1:0] addr     = 4'h0;
  logic [DATA_W-1:0] wr_data  = 16'h0000;
  logic              wr_en    = 1'b0;
  logic              rd_en    = 1'b0;
  logic              pwm      = 1'b0;
  logic              uv       = 1'b0;
  logic [NSW-1:0]    oc       = 6'h00;
  logic [NSW-1:0]    wset     = 6'h00;
  logic [NSW-1:0]    wclr     = 6'h3F;
  logic [NSW-1:0]    sd       = 6'h00;
  logic [NSW-1:0]    open     = 6'h00;
  logic              motor    = 1'b0;
  wire  [DATA_W-1:0] rd_data;
  wire  [NSW-1:0]    drive_on;
  wire  [NSW-1:0]    ol_pull_en;
  wire               therm_warn;
  hbpc_sense_t       sense;
  int                n_fail = 0;
  int                checks_done = 0;

  always #5 core_clk = ~core_clk;

  // Short delays keep the protection runs brief.
  hbpc_ctrl #(.UV_DELAY(4), .OC_DELAY(4)) u_hbpc_ctrl (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .SENSE(sense),
    .DRIVE_ON(drive_on), .OL_PULL_EN(ol_pull_en), .THERM_WARN(therm_warn));
  hbpc_plant u_hbpc_plant (
    .pwm(pwm), .uv(uv), .open_load(open), .oc(oc), .warn_set(wset),
    .warn_clr(wclr), .sd(sd), .pull_en(ol_pull_en), .drive(drive_on), .motor(motor),
    .sense(sense));

  // Verdict and end of run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Writes go to the input register only; the status word is read-only.
  task automatic wr(input logic [15:0] d);
    @(posedge core_clk);
    addr <= ADDR_INPUT;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    cmp16("read data", exp, rd_data);
  endtask

  // Stages settle a few edges after a cause; the wait is bounded.
  task automatic drv(input logic [5:0] exp);
    int i;
    i = 0;
    // Let a pending change land first, so a level that must stay is really watched.
    repeat (2) @(posedge core_clk);
    #1;
    while (drive_on !== exp && i < 40) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    cmp16("drive", {10'h000, exp}, {10'h000, drive_on});
    if (drive_on !== exp) begin
      test_done();
    end
  endtask

  task automatic clear_prot();
    wr(16'hE005);
    wr(16'hE004);
  endtask

  // The host never writes a reserved test pattern here.
  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(ADDR_INPUT, INPUT_RESET);
    rd(ADDR_STATUS, 16'h0000);
    rd(4'h9, 16'h0000);
    $display("test reset finished");
    wr(16'hE004);
    drv(6'h02);
    rd(ADDR_STATUS, 16'h0004);
    wr(16'hE104);
    drv(6'h00);
    @(posedge core_clk) pwm <= 1'b1; // One slow step, far below either PWM limit.
    drv(6'h02);
    wr(16'h6104);
    drv(6'h00);
    rd(ADDR_STATUS, 16'h4000);
    wr(16'hE004);
    drv(6'h02);
    $display("test switching finished");
    @(posedge core_clk) oc <= 6'h02;
    drv(6'h00);
    rd(ADDR_STATUS, 16'h2000);
    @(posedge core_clk) oc <= 6'h00;
    repeat (20) @(posedge core_clk);
    drv(6'h00);
    clear_prot();
    drv(6'h02);
    rd(ADDR_STATUS, 16'h0004);
    wr(16'hA004);
    @(posedge core_clk) oc <= 6'h02;
    repeat (30) @(posedge core_clk);
    drv(6'h02);
    rd(ADDR_STATUS, 16'h0004);
    @(posedge core_clk) oc <= 6'h00;
    $display("test overcurrent finished");
    @(posedge core_clk) uv <= 1'b1;
    repeat (30) @(posedge core_clk);
    drv(6'h00);
    rd(ADDR_STATUS, 16'h8000);
    @(posedge core_clk) uv <= 1'b0;
    drv(6'h02);
    rd(ADDR_STATUS, 16'h8004);
    clear_prot();
    rd(ADDR_STATUS, 16'h0004);
    $display("test supply finished");
    @(posedge core_clk) sd <= 6'h02;
    drv(6'h00);
    rd(ADDR_STATUS, 16'h2000);
    clear_prot();
    drv(6'h00);
    @(posedge core_clk) sd <= 6'h00;
    repeat (10) @(posedge core_clk);
    drv(6'h00);
    clear_prot();
    drv(6'h02);
    @(posedge core_clk) wset <= 6'h01;
    @(posedge core_clk) wclr <= 6'h00;
    repeat (10) @(posedge core_clk);
    cmp16("warning", 16'h0001, {15'h0000, therm_warn});
    rd(ADDR_STATUS, 16'h0005);
    @(posedge core_clk) wset <= 6'h00;
    repeat (10) @(posedge core_clk);
    cmp16("warning", 16'h0001, {15'h0000, therm_warn});
    @(posedge core_clk) wclr <= 6'h3F;
    repeat (10) @(posedge core_clk);
    cmp16("warning", 16'h0000, {15'h0000, therm_warn});
    $display("test thermal finished");
    @(posedge core_clk) open <= 6'h04;
    wr(16'hC000);
    repeat (10) @(posedge core_clk);
    cmp16("pull", 16'h003F, {10'h000, ol_pull_en});
    rd(ADDR_STATUS, 16'h0008);
    wr(16'hC002);
    drv(6'h01);
    repeat (10) @(posedge core_clk);
    cmp16("pull", 16'h003E, {10'h000, ol_pull_en});
    rd(ADDR_STATUS, 16'h000A);
    $display("test open load finished");
    @(posedge core_clk) open <= 6'h00;
    motor <= 1'b1;
    wr(16'hC002);
    drv(6'h01);
    repeat (10) @(posedge core_clk);
    rd(ADDR_STATUS, 16'h000A);
    wr(16'hC004);
    drv(6'h02);
    repeat (10) @(posedge core_clk);
    rd(ADDR_STATUS, 16'h0014);
    @(posedge core_clk) motor <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(ADDR_STATUS, 16'h0004);
    $display("test bridge finished");
    test_done();
  end
endmodule
